// *** hw/sccr_sck_gen.sv ***
// serial clock generator: half period of div+1 system clocks while run is high
// assumes run is held for the whole master transfer
`timescale 1ns/100ps
module sccr_sck_gen #(
    parameter int DW = 8
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    input  wire logic          run,
    input  wire logic [DW-1:0] div,
    output logic               tick,
    output logic               sck
);
    logic [DW-1:0] cnt;     // cycles in current half period
    logic [DW:0]   gap;     // check helper: cycles since last tick
    logic          gap_ok;  // check helper: a previous tick exists

    // toggle point of the serial clock
    assign tick = run & (cnt == div);

    // ==========================================================
    // divider counter; idle level low outside a transfer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            sck <= 1'h0;
        end else if (ce) begin
            if (!run) begin
                cnt <= '0;
                sck <= 1'h0;
            end else if (tick) begin
                cnt <= '0;
                sck <= ~sck;
            end else begin
                cnt <= cnt + 1'h1;
            end
        end
    end

    // ==========================================================
    // checks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap    <= '0;
            gap_ok <= 1'h0;
        end else if (ce) begin
            gap    <= tick ? (DW+1)'(1) : gap + 1'h1;
            gap_ok <= run & (gap_ok | tick);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_half_period: assert property (ce && tick && gap_ok |-> gap == {1'h0, div} + 1'h1)
        else $error("serial clock half period differs from divider plus one");
    chk_idle_level: assert property (ce && !run |=> !sck)
        else $error("serial clock not at idle level outside transfer");
    cov_toggle: cover property (ce && tick ##1 ce && tick);
endmodule

// *** hw/sccr_sync3.sv ***
// three-stage synchroniser with agreement filter for pin inputs
// assumes the inputs are asynchronous to clk
`timescale 1ns/100ps
module sccr_sync3 #(
    parameter int           W    = 4,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] ff1; // metastability stage, read by ff2 only
    logic [W-1:0] ff2; // second stage
    logic [W-1:0] ff3; // third stage

    // ==========================================================
    // per-bit pipeline; output follows once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ff1[i] <= INIT[i];
                    ff2[i] <= INIT[i];
                    ff3[i] <= INIT[i];
                    q[i]   <= INIT[i];
                end else if (ce) begin
                    ff1[i] <= d[i];
                    ff2[i] <= ff1[i];
                    ff3[i] <= ff2[i];
                    if (ff2[i] == ff3[i]) begin
                        q[i] <= ff3[i];
                    end
                end
            end
        end
    endgenerate
endmodule

// *** hw/sccr_top.sv ***
// serial port control, status and bit rate logic behind an AXI4-Lite register slave
// assumes one system clock CLK_SYS, pins sampled through three-stage synchronisers
// Functional notes
// - set done flag at every byte end
// - data write with buffer full sets collision, discarded
// - low select, master, mode 01 sets fault
// - slave overrun when unread byte completes again
// - flags interrupt, cleared only by software
// - mode 00: three-wire, select pin unused
// - mode 01: four-wire, select is input
// - mode 1x: select output equals low bit
// - data write clears buffer empty
// - move into shifter sets buffer empty
// - bit clock is clock over 2(div+1)
// - control bits set or cleared singly
// - data write loads, starts master; read returns
// - master enable selects master or slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "sccr_consts.svh"
module sccr_top (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic [11:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [11:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        SCK_I,
    output logic             SCK_O,
    output logic             SCK_OE_N,
    input  wire logic        MOSI_I,
    output logic             MOSI_O,
    output logic             MOSI_OE_N,
    input  wire logic        MISO_I,
    output logic             MISO_O,
    output logic             MISO_OE_N,
    input  wire logic        NSS_I,
    output logic             NSS_O,
    output logic             NSS_OE_N,
    output logic             IRQ
);
    // ==========================================================
    // reset release
    logic [1:0] rst_pipe; // release stages
    logic       rst_n;    // synchronised reset
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'h1};
        end
    end
    assign rst_n = rst_pipe[1];

    // ==========================================================
    // pin synchronisers
    sccr_pkg::sccr_pins_s pin_raw; // raw pin levels
    sccr_pkg::sccr_pins_s pin_s;   // filtered pin levels
    assign pin_raw = '{sck: SCK_I, mosi: MOSI_I, miso: MISO_I, chip_select_n: NSS_I};
    sccr_sync3 #(.W(4), .INIT(`SCCR_PIN_INIT)) u_sync (
        .clk   (CLK_SYS),
        .rst_n (rst_n),
        .ce    (CE),
        .d     (pin_raw),
        .q     (pin_s)
    );

    // ==========================================================
    // state
    sccr_pkg::sccr_flags_s flags;      // event flags
    sccr_pkg::sccr_state_e state;      // sequencer state
    sccr_pkg::sccr_state_e next_state; // sequencer next state
    logic [1:0] smode;     // select mode
    logic       txe;       // transmit buffer empty
    logic       en;        // port enable
    logic       master_enable;     // master enable
    logic [7:0] ckr;       // clock rate divider
    logic [7:0] txbuf;     // transmit buffer
    logic [7:0] rxbuf;     // receive buffer
    logic [7:0] shift;     // shift register
    logic       rx_full;   // receive buffer unread
    logic       in_bit;    // bit sampled at the rising edge
    logic       sck_d;     // previous synchronised clock
    logic [2:0] bitcnt;    // bits completed
    logic [3:0] irq_stat;  // sticky interrupt status
    logic [3:0] irq_en;    // interrupt enables
    logic       tick;      // serial clock toggle point
    logic       sck_lvl;   // generated serial clock

    // ==========================================================
    // register bus slave
    logic        aw_have;  // write address held
    logic        w_have;   // write data held
    logic [11:0] awaddr_q; // held write address
    logic [7:0]  wdata_q;  // held low write lane
    logic        wstrb_q;  // low lane strobe

    // byte address of a register index
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        return a == {2'h0, idx, 2'h0};
    endfunction

    wire wr_fire = aw_have & w_have & ~S_AXI_BVALID & CE;
    wire wr_ok   = wr_fire & wstrb_q;
    wire w_cfg   = wr_ok & hit(awaddr_q, `SCCR_IDX_CFG);
    wire w_ckr   = wr_ok & hit(awaddr_q, `SCCR_IDX_CKR);
    wire w_dat   = wr_ok & hit(awaddr_q, `SCCR_IDX_DAT);
    wire w_ctl   = wr_ok & hit(awaddr_q, `SCCR_IDX_CTL);
    wire w_set   = wr_ok & hit(awaddr_q, `SCCR_IDX_SET);
    wire w_clr   = wr_ok & hit(awaddr_q, `SCCR_IDX_CLR);
    wire w_iclr  = wr_ok & hit(awaddr_q, `SCCR_IDX_ICLR);
    wire w_ien   = wr_ok & hit(awaddr_q, `SCCR_IDX_IEN);
    wire wr_map  = hit(awaddr_q, `SCCR_IDX_CFG) | hit(awaddr_q, `SCCR_IDX_CKR) | hit(awaddr_q, `SCCR_IDX_DAT)
                 | hit(awaddr_q, `SCCR_IDX_CTL) | hit(awaddr_q, `SCCR_IDX_SET) | hit(awaddr_q, `SCCR_IDX_CLR)
                 | hit(awaddr_q, `SCCR_IDX_ISTAT) | hit(awaddr_q, `SCCR_IDX_ICLR) | hit(awaddr_q, `SCCR_IDX_IEN);

    assign S_AXI_AWREADY = CE & ~aw_have;
    assign S_AXI_WREADY  = CE & ~w_have;
    assign S_AXI_ARREADY = CE & ~S_AXI_RVALID;

    // read decode
    wire       rd_fire = S_AXI_ARVALID & S_AXI_ARREADY;
    wire [7:0] ctrl_now = {flags, smode, txe, en};
    wire [7:0] cfg_now  = {state != sccr_pkg::SCCR_IDLE, master_enable, 5'h00, ~rx_full | master_enable};
    wire       r_ctl = hit(S_AXI_ARADDR, `SCCR_IDX_CTL);
    wire       r_ckr = hit(S_AXI_ARADDR, `SCCR_IDX_CKR);
    wire       r_dat = hit(S_AXI_ARADDR, `SCCR_IDX_DAT);
    wire       r_cfg = hit(S_AXI_ARADDR, `SCCR_IDX_CFG);
    wire       r_ist = hit(S_AXI_ARADDR, `SCCR_IDX_ISTAT);
    wire       r_ien = hit(S_AXI_ARADDR, `SCCR_IDX_IEN);
    wire       r_wo  = hit(S_AXI_ARADDR, `SCCR_IDX_SET) | hit(S_AXI_ARADDR, `SCCR_IDX_CLR)
                     | hit(S_AXI_ARADDR, `SCCR_IDX_ICLR);
    wire       rd_map = r_ctl | r_ckr | r_dat | r_cfg | r_ist | r_ien | r_wo;
    wire [7:0] rd_val = r_ctl ? ctrl_now : r_ckr ? ckr : r_dat ? rxbuf : r_cfg ? cfg_now
                      : r_ist ? {4'h0, irq_stat} : r_ien ? {4'h0, irq_en} : 8'h00;
    wire       dat_rd = rd_fire & r_dat;

    // address and data are taken in either order; response after both
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            aw_have      <= 1'h0;
            w_have       <= 1'h0;
            awaddr_q     <= 12'h000;
            wdata_q      <= 8'h00;
            wstrb_q      <= 1'h0;
            S_AXI_BVALID <= 1'h0;
            S_AXI_BRESP  <= `SCCR_RESP_OKAY;
        end else if (CE) begin
            if (S_AXI_AWVALID & S_AXI_AWREADY) begin
                aw_have  <= 1'h1;
                awaddr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID & S_AXI_WREADY) begin
                w_have  <= 1'h1;
                wdata_q <= S_AXI_WDATA[7:0];
                wstrb_q <= S_AXI_WSTRB[0];
            end
            if (wr_fire) begin
                aw_have      <= 1'h0;
                w_have       <= 1'h0;
                S_AXI_BVALID <= 1'h1;
                S_AXI_BRESP  <= wr_map ? `SCCR_RESP_OKAY : `SCCR_RESP_SLV;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'h0;
            end
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_RVALID <= 1'h0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= `SCCR_RESP_OKAY;
        end else if (CE) begin
            if (rd_fire) begin
                S_AXI_RVALID <= 1'h1;
                S_AXI_RDATA  <= {24'h00_0000, rd_val};
                S_AXI_RRESP  <= rd_map ? `SCCR_RESP_OKAY : `SCCR_RESP_SLV;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'h0;
            end
        end
    end

    // ==========================================================
    // events and sequencing terms
    wire slave_sel  = (smode == `SCCR_MODE_3W) | ((smode == `SCCR_MODE_4W) & ~pin_s.chip_select_n);
    wire ev_mode_fault_flag    = ~pin_s.chip_select_n & master_enable & (smode == `SCCR_MODE_4W);
    wire ev_write_collision_flag    = w_dat & ~txe;
    wire in_idle    = state == sccr_pkg::SCCR_IDLE;
    wire in_m       = state == sccr_pkg::SCCR_MXFER;
    wire in_s       = state == sccr_pkg::SCCR_SXFER;
    wire master_go  = en & master_enable & ~txe & in_idle & ~ev_mode_fault_flag;
    wire slave_go   = en & ~master_enable & slave_sel & in_idle;
    wire load       = master_go | (slave_go & ~txe);
    wire bit_rise   = (in_m & tick & ~sck_lvl) | (in_s & pin_s.sck & ~sck_d);
    wire bit_fall   = (in_m & tick & sck_lvl) | (in_s & ~pin_s.sck & sck_d);
    wire ev_done    = bit_fall & (bitcnt == `SCCR_LAST_BIT);
    wire ev_ovr     = ev_done & in_s & rx_full;
    wire abort      = ~en | (in_m & (ev_mode_fault_flag | ~master_enable)) | (in_s & (master_enable | ~slave_sel));
    wire [3:0] ev   = {ev_done, ev_write_collision_flag, ev_mode_fault_flag, ev_ovr};
    wire [7:0] shifted = {shift[6:0], in_bit};

    // software view of the control register: whole write, set alias or clear alias
    wire [7:0] ctrl_sw = w_ctl ? wdata_q : w_set ? (ctrl_now | wdata_q)
                       : w_clr ? (ctrl_now & ~wdata_q) : ctrl_now;

    // ==========================================================
    // control register, configuration and interrupt registers
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            flags    <= '0;
            smode    <= `SCCR_RST_SMODE;
            en       <= 1'h0;
            master_enable    <= 1'h0;
            ckr      <= `SCCR_RST_CKR;
            irq_stat <= 4'h0;
            irq_en   <= 4'h0;
        end else if (CE) begin
            flags <= ctrl_sw[7:4] | ev;
            smode <= ctrl_sw[`SCCR_B_SMODE_HI:`SCCR_B_SMODE_LO];
            en    <= ctrl_sw[0];
            if (w_cfg) begin
                master_enable <= wdata_q[`SCCR_B_MASTER_ENABLE];
            end
            if (w_ckr) begin
                ckr <= wdata_q;
            end
            if (w_ien) begin
                irq_en <= wdata_q[3:0];
            end
            irq_stat <= (irq_stat & ~(w_iclr ? wdata_q[3:0] : 4'h0)) | ev;
        end
    end
    assign IRQ = |(irq_stat & irq_en);

    // ==========================================================
    // transmit buffer
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            txe   <= `SCCR_RST_TXE;
            txbuf <= 8'h00;
        end else if (CE) begin
            if (load) begin
                txe <= 1'h1;
            end else if (w_dat & txe) begin
                txe   <= 1'h0;
                txbuf <= wdata_q;
            end
        end
    end

    // ==========================================================
    // sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            sccr_pkg::SCCR_IDLE: begin
                if (master_go) begin
                    next_state = sccr_pkg::SCCR_MXFER;
                end else if (slave_go) begin
                    next_state = sccr_pkg::SCCR_SXFER;
                end
            end
            sccr_pkg::SCCR_MXFER, sccr_pkg::SCCR_SXFER: begin
                if (abort | ev_done) begin
                    next_state = sccr_pkg::SCCR_IDLE;
                end
            end
        endcase
    end

    // shift datapath: sample on rising edge, shift on falling edge
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            state   <= sccr_pkg::SCCR_IDLE;
            shift   <= 8'h00;
            bitcnt  <= 3'h0;
            in_bit  <= 1'h0;
            sck_d   <= 1'h0;
            rxbuf   <= 8'h00;
            rx_full <= 1'h0;
        end else if (CE) begin
            state <= next_state;
            sck_d <= pin_s.sck;
            if (master_go | slave_go) begin
                shift  <= txe ? 8'h00 : txbuf;
                bitcnt <= 3'h0;
            end
            if (bit_rise) begin
                in_bit <= master_enable ? pin_s.miso : pin_s.mosi;
            end
            if (bit_fall) begin
                shift  <= shifted;
                bitcnt <= bitcnt + 3'h1;
            end
            if (dat_rd) begin
                rx_full <= 1'h0;
            end
            if (ev_done) begin
                rx_full <= 1'h1;
                if (!rx_full) begin
                    rxbuf <= shifted; // overrun keeps the unread byte
                end
            end
        end
    end

    // bit clock generator
    sccr_sck_gen #(.DW(8)) u_sck (
        .clk   (CLK_SYS),
        .rst_n (rst_n),
        .ce    (CE),
        .run   (in_m),
        .div   (ckr),
        .tick  (tick),
        .sck   (sck_lvl)
    );

    // ==========================================================
    // pin drive (enables active low)
    assign SCK_O     = sck_lvl;
    assign SCK_OE_N  = ~(en & master_enable);
    assign MOSI_O    = shift[7];
    assign MOSI_OE_N = ~(en & master_enable);
    assign MISO_O    = shift[7];
    assign MISO_OE_N = ~in_s;
    assign NSS_O     = smode[0];
    assign NSS_OE_N  = ~smode[1];

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n);

    chk_done_flag_set: assert property (CE && ev_done |=> flags.done)
        else $error("byte end did not set done flag");
    chk_collision_discard: assert property (CE && w_dat && !txe |=> flags.write_collision_flag && $stable(txbuf))
        else $error("collision write not flagged or not discarded");
    chk_mode_fault_set: assert property (CE && !pin_s.chip_select_n && master_enable && smode == 2'h1 |=> flags.mode_fault_flag)
        else $error("mode fault not flagged");
    chk_overrun_slave: assert property (CE && in_s && ev_done && rx_full |=> flags.ovr && $stable(rxbuf))
        else $error("slave overrun not flagged");
    chk_flag_sticky: assert property (CE && flags.done && !(w_ctl || w_clr) |=> flags.done)
        else $error("done flag cleared without software");
    chk_select_output: assert property (smode[1] |-> !NSS_OE_N && NSS_O == smode[0])
        else $error("select output wrong in single master mode");
    chk_select_input: assert property (!smode[1] |-> NSS_OE_N)
        else $error("select pin driven outside single master mode");
    chk_txe_clear: assert property (CE && w_dat && txe && !load |=> !txe && txbuf == $past(wdata_q))
        else $error("buffer empty not cleared on data write");
    chk_txe_set: assert property (CE && load |=> txe)
        else $error("buffer empty not set on load");
    chk_disabled_idle: assert property (CE && !en |=> in_idle)
        else $error("disabled port left idle");
    chk_master_start: assert property (CE && master_go |=> in_m)
        else $error("master transfer did not start");
    chk_slave_role: assert property (in_s |-> !$past(master_enable))
        else $error("slave transfer while master enabled");

    cov_master_byte: cover property (in_m && ev_done);
    cov_slave_overrun: cover property (ev_ovr);
    cov_collision: cover property (ev_write_collision_flag);
    cov_mode_fault: cover property (in_m && ev_mode_fault_flag);
endmodule

// *** shared/sccr_consts.svh ***
// constants of the serial port control block: register indices, field positions, reset values
// assumes a 12-bit byte address, registers one aligned word each at four times their index
`ifndef SCCR_CONSTS_SVH
`define SCCR_CONSTS_SVH

// ==========================================================
// register indices (byte address = index * 4)
`define SCCR_IDX_CFG    8'hA1
`define SCCR_IDX_CKR    8'hA2
`define SCCR_IDX_DAT    8'hA3
`define SCCR_IDX_CTL    8'hF8
`define SCCR_IDX_SET    8'hF9
`define SCCR_IDX_CLR    8'hFA
`define SCCR_IDX_ISTAT  8'hFC
`define SCCR_IDX_ICLR   8'hFD
`define SCCR_IDX_IEN    8'hFE

// ==========================================================
// field positions
`define SCCR_B_MASTER_ENABLE    6
`define SCCR_B_BUSY     7
`define SCCR_B_RXBMT    0
`define SCCR_B_SMODE_HI 3
`define SCCR_B_SMODE_LO 2

// ==========================================================
// reset values and codes
`define SCCR_RST_SMODE  2'h1
`define SCCR_RST_TXE    1'h1
`define SCCR_RST_CKR    8'h00
`define SCCR_MODE_3W    2'h0
`define SCCR_MODE_4W    2'h1
`define SCCR_LAST_BIT   3'h7
`define SCCR_RESP_OKAY  2'h0
`define SCCR_RESP_SLV   2'h2
`define SCCR_PIN_INIT   4'h1

`endif

// *** shared/sccr_pkg.sv ***
// types shared by the serial port control block
// assumes nothing beyond a SystemVerilog compiler
package sccr_pkg;
    // transfer sequencer states
    typedef enum logic [1:0] {SCCR_IDLE, SCCR_MXFER, SCCR_SXFER} sccr_state_e;
    // the four event flags, in control register order
    typedef struct packed {
        logic done;
        logic write_collision_flag;
        logic mode_fault_flag;
        logic ovr;
    } sccr_flags_s;
    // pin inputs that cross into the system clock
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic chip_select_n;
    } sccr_pins_s;
endpackage

// *** tb/sccr_bench.sv ***
// register-level bench of the serial port control block
// assumes the partner slave answers on miso, select driven by the port
`timescale 1ns/100ps
`include "sccr_consts.svh"
module sccr_bench;
    logic CLK_SYS = 0, RST_N = 0, NSS_I = 1, SCK_I = 0, MOSI_I = 0, aw = 0, w = 0, br = 0, ar = 0, rr = 0;
    logic [11:0] a = 0, ra = 0;
    logic [31:0] wd = 0, q;
    logic [1:0] rsp, wrsp;
    logic SCK_O, MOSI_O, NSS_O, NSS_OE_N, IRQ, miso, AWR, WR, BV, ARR, RV, MO, MOE;
    logic [31:0] RD;
    logic [1:0] RR, BR;
    logic [7:0] got, mb;
    int n_fail = 0, num_checks = 0, cyc = 0;
    realtime t0 = 0;
    always #5 CLK_SYS = ~CLK_SYS;
    sccr_top u_sccr_top (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(1'b1), .S_AXI_AWADDR(a), .S_AXI_AWVALID(aw),
        .S_AXI_AWREADY(AWR), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w), .S_AXI_WREADY(WR),
        .S_AXI_BRESP(BR), .S_AXI_BVALID(BV), .S_AXI_BREADY(br), .S_AXI_ARADDR(ra), .S_AXI_ARVALID(ar),
        .S_AXI_ARREADY(ARR), .S_AXI_RDATA(RD), .S_AXI_RRESP(RR), .S_AXI_RVALID(RV), .S_AXI_RREADY(rr),
        .SCK_I(SCK_I), .SCK_O(SCK_O), .SCK_OE_N(), .MOSI_I(MOSI_I), .MOSI_O(MOSI_O), .MOSI_OE_N(),
        .MISO_I(miso), .MISO_O(MO), .MISO_OE_N(MOE), .NSS_I(NSS_I), .NSS_O(NSS_O), .NSS_OE_N(NSS_OE_N), .IRQ(IRQ));
    sccr_partner u_sccr_partner (.sck(SCK_O), .sel_n(NSS_O), .mosi(MOSI_O), .miso(miso), .got(got));
    // ==========================================================
    // bus tasks and compare
    task ck(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge CLK_SYS);
        aw <= 1; w <= 1; br <= 1; a <= {i, 2'b00}; wd <= {24'h0, d};
        do begin
            @(posedge CLK_SYS);
            if (aw && AWR) aw <= 0;
            if (w && WR) w <= 0;
        end while (!BV);
        wrsp = BR;
        br <= 0;
    endtask
    // far-side master for slave mode: one byte, msb first, half period of 8 clocks;
    // the port's miso bit is taken just before each rising clock edge
    task sb(input logic [7:0] b, output logic [7:0] m);
        for (int i = 7; i >= 0; i--) begin
            MOSI_I <= b[i];
            repeat (8) @(posedge CLK_SYS);
            m = {m[6:0], MO};
            SCK_I <= 1;
            repeat (8) @(posedge CLK_SYS);
            SCK_I <= 0;
        end
        repeat (8) @(posedge CLK_SYS);
    endtask
    task rd(input logic [7:0] i);
        @(posedge CLK_SYS);
        ar <= 1; rr <= 1; ra <= {i, 2'b00};
        do begin
            @(posedge CLK_SYS);
            if (ar && ARR) ar <= 0;
        end while (!RV);
        q = RD; rsp = RR; rr <= 0;
    endtask
    task results;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // watchdogs: run limit and bit clock period (divider 4 -> 100 ns)
    always @(posedge CLK_SYS) if (++cyc == 20000) begin
        n_fail++;
        results();
    end
    always @(posedge SCK_O) begin
        if (t0 != 0) ck("sck period", 100, int'($realtime - t0));
        t0 = $realtime;
    end
    // ==========================================================
    // test sequence
    initial begin
        repeat (8) @(posedge CLK_SYS);
        RST_N <= 1;
        repeat (3) @(posedge CLK_SYS);
        rd(`SCCR_IDX_CTL); ck("ctl reset", 32'h06, q);
        rd(8'h00); ck("unmapped resp", 2, rsp);
        wr(`SCCR_IDX_IEN, 8'h0F);
        wr(`SCCR_IDX_CKR, 8'h04); rd(`SCCR_IDX_CKR); ck("divider", 32'h04, q);
        wr(`SCCR_IDX_CFG, 8'h40);
        wr(`SCCR_IDX_CTL, 8'h0C); ck("nss mode 11", 1, {NSS_OE_N, NSS_O});
        wr(`SCCR_IDX_CTL, 8'h08); ck("nss mode 10", 0, NSS_O);
        wr(`SCCR_IDX_DAT, 8'hA5); wr(`SCCR_IDX_DAT, 8'h11);
        rd(`SCCR_IDX_CTL); ck("ctl write_collision_flag", 32'h48, q);
        wr(`SCCR_IDX_SET, 8'h01);
        do rd(`SCCR_IDX_CTL); while (!q[7]);
        ck("ctl done", 32'hCB, q);
        ck("mosi byte", 8'hA5, got);
        rd(`SCCR_IDX_DAT); ck("rx byte", 32'h3C, q);
        rd(`SCCR_IDX_ISTAT); ck("irq status", 32'h0C, q);
        ck("irq line", 1, IRQ);
        wr(`SCCR_IDX_CLR, 8'hC0); rd(`SCCR_IDX_CTL); ck("ctl clr", 32'h0B, q);
        wr(`SCCR_IDX_ICLR, 8'h0F); ck("irq off", 0, IRQ);
        wr(`SCCR_IDX_CTL, 8'h05); NSS_I <= 0; repeat (8) @(posedge CLK_SYS); NSS_I <= 1;
        rd(`SCCR_IDX_CTL); ck("ctl mode_fault_flag", 32'h27, q);
        ck("irq mode_fault_flag", 1, IRQ);
        wr(8'h00, 8'h00); ck("unmapped write resp", 2, wrsp);
        wr(`SCCR_IDX_CFG, 8'h00); wr(`SCCR_IDX_DAT, 8'h96); wr(`SCCR_IDX_CTL, 8'h01);
        sb(8'h5A, mb); ck("miso byte", 8'h96, mb);
        ck("miso driven", 0, MOE); ck("nss mode 00", 1, NSS_OE_N);
        sb(8'hC3, mb);
        rd(`SCCR_IDX_CTL); ck("ctl ovr", 32'h93, q);
        rd(`SCCR_IDX_DAT); ck("rx kept", 32'h5A, q);
        rd(`SCCR_IDX_ISTAT); ck("irq slave", 32'h0B, q);
        results();
    end
endmodule

// *** tb/sccr_partner.sv ***
// behavioural spi slave at the far side of the port, clock mode 0
// assumes sel_n low frames a byte; sck idles low
`timescale 1ns/100ps
module sccr_partner #(
    parameter logic [7:0] REPLY = 8'h3C
) (
    input  wire logic       sck,
    input  wire logic       sel_n,
    input  wire logic       mosi,
    output logic            miso,
    output logic [7:0]      got
);
    logic [7:0] sh = REPLY;  // reply shifter, msb first
    initial got = 8'h00;
    // released line shows the inverse so a stale bit never passes
    assign miso = sel_n ? ~sh[7] : sh[7];
    // sample on rising, shift on falling
    always @(posedge sck) if (!sel_n) got <= {got[6:0], mosi};
    always @(negedge sck) if (!sel_n) sh <= {sh[6:0], 1'b0};
endmodule
